// ==== logic/can_stat_pkg.sv ====
package can_stat_pkg;
  // ************************
  // register map
  // ************************
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] FILTER_USE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IFLAG_OFS = 8'h0c;
  localparam logic [7:0] IENABLE_OFS = 8'h10;
  localparam logic [7:0] ICLEAR_OFS = 8'h14;
  // ************************
  // field positions and counts
  // ************************
  localparam int CORE_EN_POS = 0;
  localparam int FBUSY_POS = 20;
  localparam int TXFULL_POS = 21;
  localparam int PBFULL_POS = 22;
  localparam int ESTATE_LO = 23;
  localparam int EWARN_POS = 25;
  localparam int BACTIVE_POS = 26;
  localparam int BQUIET_POS = 27;
  localparam int NORMAL_POS = 28;
  localparam int SLEEP_POS = 29;
  localparam int LOOPBACK_POS = 30;
  localparam int CONFIG_POS = 31;
  localparam int FLAG_LO = 20;
  localparam int NFLAGS = 12;
  localparam int RXDONE_IDX = 7;
  localparam int TXDONE_IDX = 10;
  localparam int MAX_FILTERS = 4;
  // ************************
  // values
  // ************************
  localparam logic [1:0] ES_CONFIG = 2'h0;
  localparam logic [1:0] ES_ACTIVE = 2'h1;
  localparam logic [1:0] ES_PASSIVE = 2'h3;
  localparam logic [1:0] ES_BUS_OFF = 2'h2;
  localparam logic [7:0] WARN_LEVEL = 8'h60;
  localparam logic [31:0] STATUS_RST = 32'h8000_0000;
  localparam logic [11:0] ENABLE_CLEAR_MASK = 12'hcaf;
  localparam logic [3:0] FILTER_USE_RST = 4'h0;

  typedef struct packed {
    logic arbitration_lost_event;
    logic transmit_done_event;
    logic tx_queue_full;
    logic priority_buffer_full;
    logic receive_done_event;
    logic receive_underflow_event;
    logic receive_overflow_event;
    logic receive_queue_nonempty;
    logic error_event;
    logic bus_off_event;
    logic sleep_entry_event;
    logic wake_event;
  } can_events_t;

  typedef struct packed {
    logic tx_queue_full;
    logic priority_buffer_full;
    logic [7:0] tx_err_count;
    logic [7:0] rx_err_count;
    logic bus_off;
    logic error_passive;
    logic frame_active;
    logic normal_mode;
    logic sleep_mode;
    logic loopback_mode;
  } engine_state_t;
endpackage : can_stat_pkg

// ==== logic/can_status_irq.sv ====
`timescale 1ns/1ps
module can_status_irq #(
  parameter int NUM_FILTERS = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire can_stat_pkg::engine_state_t i_engine,
  input wire can_stat_pkg::can_events_t i_events,
  input wire logic i_filter_update_done,
  output logic o_filter_write_lock,
  output logic o_core_enable,
  output logic o_irq
);
  import can_stat_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic core_enable;
    logic [3:0] filter_use;
    logic filter_busy;
    logic [31:0] status;
    logic [11:0] flags;
    logic [11:0] enables;
    logic tx_done_pend;
    logic irq;
  } state_t;

  state_t cur;
  state_t next_s;

  localparam logic [3:0] FILTER_VALID =
    4'((5'h1 << NUM_FILTERS) - 5'h1);

  // ************************
  // helpers
  // ************************
  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : byte_mask

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = byte_mask(sel);
    return (old & ~m) | (nw & m);
  endfunction : merge

  // ************************
  // next state
  // ************************
  logic req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] ctrl_new;
  logic [31:0] fuse_new;
  logic [31:0] ien_new;
  logic [11:0] set_v;
  logic [11:0] clr_v;
  logic in_cfg;
  logic [31:0] st;

  always_comb begin
    req = i_wb_cyc && i_wb_stb && !cur.ack;
    wr = req && i_wb_we;
    wmask = byte_mask(i_wb_sel);
    ctrl_new = merge({31'h0, cur.core_enable}, i_wb_dat, i_wb_sel);
    fuse_new = merge({28'h0, cur.filter_use}, i_wb_dat, i_wb_sel);
    ien_new = merge({cur.enables, 20'h0}, i_wb_dat, i_wb_sel);
    next_s = cur;
    next_s.ack = req;
    next_s.rdata = 32'h0;

    // register writes
    if (wr && i_wb_adr == CONTROL_OFS) begin
      next_s.core_enable = ctrl_new[CORE_EN_POS];
    end
    if (wr && i_wb_adr == FILTER_USE_OFS) begin
      next_s.filter_use = fuse_new[3:0] & FILTER_VALID;
    end
    if (wr && i_wb_adr == IENABLE_OFS) begin
      next_s.enables = ien_new[31:FLAG_LO];
    end

    if (i_filter_update_done) begin
      next_s.filter_busy = 1'b0;
    end
    if (NUM_FILTERS != 0 && wr && i_wb_adr == FILTER_USE_OFS &&
        |(~fuse_new[3:0] & FILTER_VALID)) begin
      next_s.filter_busy = 1'b1;
    end
    if (NUM_FILTERS == 0) begin
      next_s.filter_busy = 1'b0;
    end

    set_v = i_events;
    next_s.tx_done_pend = 1'b0;
    if (cur.tx_done_pend) begin
      set_v[TXDONE_IDX] = 1'b1;
    end
    if (i_engine.loopback_mode && i_events.transmit_done_event &&
        !(cur.flags[RXDONE_IDX] || i_events.receive_done_event)) begin
      set_v[TXDONE_IDX] = cur.tx_done_pend;
      next_s.tx_done_pend = 1'b1;
    end else if (i_engine.loopback_mode &&
                 i_events.transmit_done_event &&
                 i_events.receive_done_event) begin
      set_v[TXDONE_IDX] = cur.tx_done_pend;
      next_s.tx_done_pend = 1'b1;
    end

    clr_v = 12'h0;
    if (wr && i_wb_adr == ICLEAR_OFS) begin
      clr_v = i_wb_dat[31:FLAG_LO] & wmask[31:FLAG_LO];
    end
    if (wr && i_wb_adr == CONTROL_OFS && !ctrl_new[CORE_EN_POS]) begin
      clr_v = clr_v | ENABLE_CLEAR_MASK;
    end
    next_s.flags = (cur.flags & ~clr_v) | set_v;

    next_s.irq = |(next_s.flags & next_s.enables);

    in_cfg = !next_s.core_enable;
    st = 32'h0;
    st[FBUSY_POS] = next_s.filter_busy;
    st[TXFULL_POS] = i_engine.tx_queue_full;
    st[PBFULL_POS] = i_engine.priority_buffer_full;
    if (in_cfg) begin
      st[ESTATE_LO +: 2] = ES_CONFIG;
    end else if (i_engine.bus_off) begin
      st[ESTATE_LO +: 2] = ES_BUS_OFF;
    end else if (i_engine.error_passive) begin
      st[ESTATE_LO +: 2] = ES_PASSIVE;
    end else begin
      st[ESTATE_LO +: 2] = ES_ACTIVE;
    end
    st[EWARN_POS] = (i_engine.tx_err_count >= WARN_LEVEL) ||
                    (i_engine.rx_err_count >= WARN_LEVEL);
    st[BACTIVE_POS] = !in_cfg && i_engine.frame_active;
    st[BQUIET_POS] = !in_cfg && !i_engine.frame_active;
    st[NORMAL_POS] = !in_cfg && i_engine.normal_mode;
    st[SLEEP_POS] = !in_cfg && i_engine.sleep_mode;
    st[LOOPBACK_POS] = !in_cfg && i_engine.loopback_mode;
    st[CONFIG_POS] = in_cfg;
    next_s.status = st;

    // read mux, no side effects
    if (req && !i_wb_we) begin
      case (i_wb_adr)
        CONTROL_OFS: next_s.rdata = {31'h0, cur.core_enable};
        FILTER_USE_OFS: next_s.rdata = {28'h0, cur.filter_use};
        STATUS_OFS: next_s.rdata = cur.status;
        IFLAG_OFS: next_s.rdata = {cur.flags, 20'h0};
        IENABLE_OFS: next_s.rdata = {cur.enables, 20'h0};
        default: next_s.rdata = 32'h0;
      endcase
    end
  end

  // ************************
  // state register
  // ************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      cur <= '0;
      cur.status <= STATUS_RST;
      cur.filter_use <= FILTER_USE_RST;
    end else begin
      cur <= next_s;
    end
  end

  assign o_wb_ack = cur.ack;
  assign o_wb_dat = cur.rdata;
  assign o_filter_write_lock = cur.filter_busy;
  assign o_core_enable = cur.core_enable;
  assign o_irq = cur.irq;

  // ************************
  // checks
  // ************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  busy_set_a: assert property (
    (NUM_FILTERS != 0) && wr && i_wb_adr == FILTER_USE_OFS &&
    |(~i_wb_dat[3:0] & FILTER_VALID) && i_wb_sel[0]
    |=> o_filter_write_lock && cur.status[FBUSY_POS])
    else $error("filter busy not set");
  busy_done_a: assert property (
    o_filter_write_lock && i_filter_update_done && !(wr && i_wb_adr == FILTER_USE_OFS)
    |=> !o_filter_write_lock)
    else $error("filter busy not released");
  busy_absent_a: assert property (
    (NUM_FILTERS == 0) |-> !cur.status[FBUSY_POS])
    else $error("filter busy without filters");
  txfull_track_a: assert property (
    i_engine.tx_queue_full |=> cur.status[TXFULL_POS])
    else $error("queue full not shown");
  pbfull_set_a: assert property (
    i_engine.priority_buffer_full |=> cur.status[PBFULL_POS])
    else $error("buffer full not shown");
  pbfull_free_a: assert property (
    !i_engine.priority_buffer_full |=> !cur.status[PBFULL_POS])
    else $error("buffer free shown full");
  estate_boff_a: assert property (
    o_core_enable && !(wr && i_wb_adr == CONTROL_OFS) && i_engine.bus_off |=>
    cur.status[ESTATE_LO +: 2] == ES_BUS_OFF)
    else $error("bus off code wrong");
  estate_pass_a: assert property (
    o_core_enable && !(wr && i_wb_adr == CONTROL_OFS) && !i_engine.bus_off &&
    i_engine.error_passive |=> cur.status[ESTATE_LO +: 2] == ES_PASSIVE)
    else $error("passive code wrong");
  estate_cfg_a: assert property (
    !o_core_enable |-> cur.status[ESTATE_LO +: 2] == ES_CONFIG)
    else $error("config code wrong");
  warn_level_a: assert property (
    i_engine.tx_err_count == 8'h5f && i_engine.rx_err_count < 8'h60
    |=> !cur.status[EWARN_POS])
    else $error("warning below 96");
  warn_high_a: assert property (
    i_engine.rx_err_count == 8'h60 |=> cur.status[EWARN_POS])
    else $error("warning at 96 missing");
  bus_busy_a: assert property (
    o_core_enable && !(wr && i_wb_adr == CONTROL_OFS) && i_engine.frame_active
    |=> cur.status[BACTIVE_POS] && !cur.status[BQUIET_POS])
    else $error("bus busy not shown");
  bus_idle_a: assert property (
    o_core_enable && !(wr && i_wb_adr == CONTROL_OFS) && !i_engine.frame_active
    |=> cur.status[BQUIET_POS] && !cur.status[BACTIVE_POS])
    else $error("bus idle not shown");
  normal_mode_a: assert property (
    o_core_enable && !(wr && i_wb_adr == CONTROL_OFS)
    |=> cur.status[NORMAL_POS] == $past(i_engine.normal_mode))
    else $error("normal mode bit wrong");
  sleep_mode_a: assert property (
    o_core_enable && !(wr && i_wb_adr == CONTROL_OFS)
    |=> cur.status[SLEEP_POS] == $past(i_engine.sleep_mode))
    else $error("sleep mode bit wrong");
  loop_mode_a: assert property (
    o_core_enable && !(wr && i_wb_adr == CONTROL_OFS)
    |=> cur.status[LOOPBACK_POS] == $past(i_engine.loopback_mode))
    else $error("loopback bit wrong");
  config_bits_a: assert property (
    !o_core_enable |-> cur.status[CONFIG_POS] &&
    cur.status[BQUIET_POS +: 4] == 4'h0)
    else $error("config status wrong");
  low_zero_a: assert property (
    cur.status[19:0] == 20'h0)
    else $error("low status bits set");
  irq_set_a: assert property (
    i_events.error_event && cur.enables[3] && !(wr && i_wb_adr == IENABLE_OFS)
    |=> o_irq)
    else $error("interrupt missing after event");
  irq_level_a: assert property (
    |(cur.flags & cur.enables) && !(wr && (i_wb_adr == ICLEAR_OFS ||
    i_wb_adr == IENABLE_OFS || i_wb_adr == CONTROL_OFS)) |=> o_irq)
    else $error("interrupt not asserted");
  irq_gate_a: assert property (
    (cur.enables == 12'h0) && !(wr && i_wb_adr == IENABLE_OFS) |=> !o_irq)
    else $error("interrupt without enable");
  clear_sel_a: assert property (
    wr && i_wb_adr == ICLEAR_OFS && i_wb_sel[3] && i_wb_dat[31] &&
    !i_events.arbitration_lost_event |=> !cur.flags[NFLAGS-1])
    else $error("selected flag not cleared");
  set_wins_a: assert property (
    i_events.error_event && wr && i_wb_adr == ICLEAR_OFS
    |=> cur.flags[3])
    else $error("clear beat set");
  flag_msb_a: assert property (
    i_events.arbitration_lost_event |=> cur.flags[NFLAGS-1])
    else $error("top flag not set");
  flag_low_a: assert property (
    req && !i_wb_we && i_wb_adr == IFLAG_OFS |=> o_wb_dat[FLAG_LO-1:0] == 20'h0)
    else $error("unused flag bits set");
  disable_clr_a: assert property (
    wr && i_wb_adr == CONTROL_OFS && i_wb_sel[0] && !i_wb_dat[CORE_EN_POS] &&
    !i_events.wake_event |=> !cur.flags[0])
    else $error("disable kept wake flag");
  sticky_a: assert property (
    cur.flags[4] && !(wr && i_wb_adr == ICLEAR_OFS)
    |=> cur.flags[4])
    else $error("nonempty flag lost");
  loop_order_a: assert property (
    i_engine.loopback_mode && i_events.transmit_done_event && i_events.receive_done_event &&
    !cur.flags[TXDONE_IDX] && !cur.tx_done_pend
    |=> cur.flags[RXDONE_IDX] && !cur.flags[TXDONE_IDX] ##1 cur.flags[TXDONE_IDX])
    else $error("transmit done before receive done");
  read_clean_a: assert property (
    req && !i_wb_we && i_events == 12'h0 && !cur.tx_done_pend
    |=> cur.flags == $past(cur.flags))
    else $error("read changed flags");
  ack_once_a: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held");
  ack_next_a: assert property (
    req |=> o_wb_ack)
    else $error("ack missing");
  dat_idle_a: assert property (
    !o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data without ack");
  cov_irq: cover property (o_irq ##1 !o_irq);
  cov_busy: cover property ($rose(o_filter_write_lock));
  cov_loop: cover property (cur.tx_done_pend);
  cov_clear: cover property (wr && i_wb_adr == ICLEAR_OFS);
  cov_order: cover property (cur.flags[RXDONE_IDX] && !cur.flags[TXDONE_IDX] ##1 cur.flags[TXDONE_IDX]);
endmodule : can_status_irq

// ==== dv/wb_host_model.sv ====
`timescale 1ns/1ps
// ************
// host master
// ************
module wb_host_model (
  input wire logic i_core_clk,
  input wire logic i_ack,
  input wire logic [31:0] i_rdat,
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [7:0] o_adr,
  output logic [3:0] o_sel,
  output logic [31:0] o_dat
);
  initial begin
    o_cyc = 1'h0;
    o_stb = 1'h0;
    o_we = 1'h0;
    o_adr = 8'h0;
    o_sel = 4'h0;
    o_dat = 32'h0;
  end
  // one bus transfer, read or write
  // no wait bound here: the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    @(posedge i_core_clk);
    o_cyc <= 1'h1;
    o_stb <= 1'h1;
    o_we <= w;
    o_adr <= a;
    o_sel <= s;
    o_dat <= d;
    do @(posedge i_core_clk); while (i_ack !== 1'h1);
    q = i_rdat;
    o_cyc <= 1'h0;
    o_stb <= 1'h0;
    o_we <= 1'h0;
    o_dat <= ~d;
  endtask : xfer
endmodule : wb_host_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
  import can_stat_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic fdone = 1'h0;
  logic cyc, stb, we, ack, lock, core_enable_bit, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  engine_state_t eng = '0;
  can_events_t ev = '0;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  can_status_irq #(.NUM_FILTERS(4)) dut_u (.i_core_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_engine(eng), .i_events(ev), .i_filter_update_done(fdone), .o_filter_write_lock(lock),
    .o_core_enable(core_enable_bit), .o_irq(irq));
  wb_host_model host_u (.i_core_clk(clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we),
    .o_adr(adr), .o_sel(sel), .o_dat(wdat));
  // ************
  // helpers
  // ************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    host_u.xfer(1'h0, a, 32'h0, 4'hf, q);
    chk(n, e, q);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] q;
    host_u.xfer(1'h1, a, d, s, q);
  endtask : wr
  task automatic pulse(input logic [11:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask : pulse
  // enabled-core status expected from the engine levels
  function automatic logic [31:0] sx(engine_state_t e);
    logic [31:0] s;
    s = 32'h0;
    s[21] = e.tx_queue_full;
    s[22] = e.priority_buffer_full;
    s[24:23] = e.bus_off ? 2'h2 : (e.error_passive ? 2'h3 : 2'h1);
    s[25] = (e.tx_err_count >= 8'h60) || (e.rx_err_count >= 8'h60);
    s[26] = e.frame_active;
    s[27] = !e.frame_active;
    s[28] = e.normal_mode;
    s[29] = e.sleep_mode;
    s[30] = e.loopback_mode;
    return s;
  endfunction : sx
  task automatic st(input engine_state_t v);
    eng <= v;
    repeat (2) @(posedge clk);
    rd(STATUS_OFS, sx(v), "status");
  endtask : st
  // ************
  // scenarios
  // ************
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    rd(STATUS_OFS, STATUS_RST, "status reset");
    rd(IFLAG_OFS, 32'h0, "flags reset");
    rd(8'h40, 32'h0, "unmapped");
    chk("irq reset", 32'h0, irq);
    wr(CONTROL_OFS, 32'h1);
    chk("core enable", 32'h1, core_enable_bit);
    st({2'h0, 8'h5f, 8'h00, 2'h0, 4'h4});
    st({2'h3, 8'h00, 8'h60, 2'h1, 4'hd});
    st({2'h0, 8'hff, 8'h00, 2'h2, 4'h2});
    wr(FILTER_USE_OFS, 32'hf);
    rd(STATUS_OFS, sx(eng), "no filter busy");
    wr(FILTER_USE_OFS, 32'he);
    rd(STATUS_OFS, sx(eng) | 32'h0010_0000, "filter busy");
    chk("lock", 32'h1, lock);
    @(posedge clk);
    fdone <= 1'h1;
    @(posedge clk);
    fdone <= 1'h0;
    rd(STATUS_OFS, sx(eng), "busy done");
    eng <= {2'h0, 8'h00, 8'h00, 2'h0, 4'h4};
    for (int i = 0; i < 12; i++) begin
      wr(IENABLE_OFS, 32'h1 << (20 + (i + 1) % 12));
      pulse(12'h1 << i);
      rd(IFLAG_OFS, 32'h1 << (20 + i), "flag");
      rd(IFLAG_OFS, 32'h1 << (20 + i), "flag reread");
      chk("irq masked", 32'h0, irq);
      wr(IENABLE_OFS, 32'h1 << (20 + i));
      repeat (2) @(posedge clk);
      chk("irq on", 32'h1, irq);
      wr(ICLEAR_OFS, 32'hffff_ffff);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, irq);
    end
    // events stand only at the edge that takes the clear
    fork
      wr(ICLEAR_OFS, 32'hffff_ffff);
      begin
        @(posedge clk);
        ev <= 12'hfff;
        @(posedge clk);
        ev <= '0;
      end
    join
    rd(IFLAG_OFS, 32'hfff0_0000, "set over clear");
    wr(ICLEAR_OFS, 32'hffff_ffff, 4'h7);
    rd(IFLAG_OFS, 32'hff00_0000, "lane clear");
    wr(CONTROL_OFS, 32'h0);
    rd(IFLAG_OFS, 32'h3500_0000, "disable clear");
    rd(STATUS_OFS, STATUS_RST, "config again");
    wr(ICLEAR_OFS, 32'hffff_ffff);
    rd(IFLAG_OFS, 32'h0, "clear rest");
    wr(CONTROL_OFS, 32'h1);
    eng.loopback_mode <= 1'h1;
    wr(IENABLE_OFS, 32'h4000_0000);
    @(posedge clk);
    ev <= 12'h480;
    @(posedge clk);
    ev <= '0;
    #1;
    chk("tx done late", 32'h0, irq);
    @(posedge clk);
    #1;
    chk("tx done", 32'h1, irq);
    rd(IFLAG_OFS, 32'h4800_0000, "loop flags");
    print_verdict();
  end
endmodule : tb
